// ===== include/uart_ctrl_pkg.sv
// Function
// - a completed character moved into the receive data register clears overrun
// - status bits 2..0 are reserved and always read zero
// - receive-complete interrupt requested when its enable, global enable and flag are set
// - transmit-complete interrupt requested when its enable, global enable and flag are set
// - data-register-empty interrupt requested when its enable, global enable and flag are set
// - receiver works only when enabled; otherwise its flags never set
// - disabling the receiver leaves already set receive flags unchanged
// - disabling the transmitter still finishes the shifting and the waiting character
// - nine-bit select makes both directions carry nine data bits, else eight
// - ninth received bit lands in control bit 1 with each character moved into the receive data register
// - control bit 0 is sent as the ninth data bit
// - enabled transmitter forces the transmit pin to output
// - enabled receiver forces the receive pin to input
// - forced receive input with port data bit one turns on the pull-up
// - receive pin passes a synchronizer before the receiver samples it
// - a character completing while the previous is unread sets overrun
// - a stop bit sampled as one clears the framing error flag when its character is moved into the receive data register
`default_nettype none
package uart_ctrl_pkg;

  // ***************************************
  // register indices, byte address is index times four
  // ***************************************
  localparam logic [5:0] IDX_BAUD = 6'h09;
  localparam logic [5:0] IDX_CONTROL = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_DATA = 6'h0c;
  localparam logic [5:0] IDX_EVENT = 6'h0d;
  localparam logic [5:0] IDX_MASK = 6'h0e;
  localparam logic [5:0] IDX_PIN_IN = 6'h10;
  localparam logic [5:0] IDX_PORT_DIR = 6'h11;
  localparam logic [5:0] IDX_PORT_OUT = 6'h12;

  // ***************************************
  // reset values
  // ***************************************
  localparam logic [7:0] CONTROL_RESET = 8'h02;
  localparam logic [15:0] BAUD_RESET = 16'h043c;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // ***************************************
  // field positions
  // ***************************************
  localparam int RX_PIN_BIT = 0;
  localparam int TX_PIN_BIT = 1;
  localparam int EVT_RX_DONE = 0;
  localparam int EVT_TX_DONE = 1;
  localparam int EVT_DATA_EMPTY = 2;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic rx_done_irq_en;
    logic tx_done_irq_en;
    logic data_empty_irq_en;
    logic receiver_on;
    logic transmitter_on;
    logic nine_bit_select;
    logic rx_ninth_bit;
    logic tx_ninth_bit;
  } serial_control_t;

  typedef struct packed {
    logic rx_done_flag;
    logic tx_done_flag;
    logic data_empty_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic [2:0] reserved;
  } serial_status_t;

  typedef enum logic [1:0] {
    LINE_IDLE = 2'b00,
    LINE_START = 2'b01,
    LINE_DATA = 2'b11,
    LINE_STOP = 2'b10
  } line_state_t;

endpackage
`default_nettype wire

// ===== core/uart_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic global_irq_en_i,
  output logic rx_irq_o,
  output logic tx_irq_o,
  output logic empty_irq_o,
  output logic irq_o,
  input wire logic rx_pin_i,
  output logic rx_pin_o,
  output logic rx_pin_oe_o,
  output logic rx_pullup_o,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe_o
);
  import uart_ctrl_pkg::*;

  // ***************************************
  // declarations
  // ***************************************
  serial_control_t ctrl_q;
  serial_status_t status_w;
  logic [15:0] baud_q;
  logic [7:0] port_dir_q;
  logic [7:0] port_out_q;
  logic [2:0] evt_q;
  logic [2:0] mask_q;
  logic [1:0] sync1_q, sync2_q, sync3_q, pin_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic req_w, acc_w, wr_w, rd_w;
  logic [5:0] idx_w;
  logic rx_done_q, overrun_q, framing_q, tx_done_q;
  logic [7:0] rx_data_q;
  line_state_t rx_state_q, tx_state_q;
  logic [15:0] rx_cnt_q, tx_cnt_q;
  logic [3:0] rx_bit_q, tx_bit_q;
  logic [8:0] rx_shift_q, tx_shift_q;
  logic rx_end_w, rx_stop_w;
  logic [3:0] last_bit_w;
  logic [7:0] txd_q;
  logic txd_full_q;
  logic tx_load_w, tx_fin_w, tx_line_q;
  logic rd_data_w, wr_data_w;

  assign req_w = avs_read_i | avs_write_i;
  assign acc_w = req_w & ~wait_q;
  assign wr_w = acc_w & avs_write_i;
  assign rd_w = acc_w & avs_read_i;
  assign idx_w = avs_address_i[7:2];
  assign rd_data_w = rd_w && (idx_w == IDX_DATA);
  assign wr_data_w = wr_w && (idx_w == IDX_DATA) && avs_byteenable_i[0];
  assign last_bit_w = ctrl_q.nine_bit_select ? 4'h8 : 4'h7;

  // ***************************************
  // status view, low bits tied to zero
  // ***************************************
  assign status_w.rx_done_flag = rx_done_q;
  assign status_w.tx_done_flag = tx_done_q;
  assign status_w.data_empty_flag = ~txd_full_q;
  assign status_w.framing_error_flag = framing_q;
  assign status_w.overrun_flag = overrun_q;
  assign status_w.reserved = 3'h0;

  // ***************************************
  // avalon slave handshake
  // ***************************************
  // waitrequest drops for the one cycle in which the access completes
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req_w & wait_q);
    end
  end

  // read data sampled one cycle ahead so it stands at the completing edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0;
    end else if (avs_read_i && wait_q) begin
      if (idx_w == IDX_BAUD) begin
        rdata_q <= {16'h0, baud_q};
      end else if (idx_w == IDX_CONTROL) begin
        rdata_q <= {24'h0, ctrl_q};
      end else if (idx_w == IDX_STATUS) begin
        rdata_q <= {24'h0, status_w};
      end else if (idx_w == IDX_DATA) begin
        rdata_q <= {24'h0, rx_data_q};
      end else if (idx_w == IDX_EVENT) begin
        rdata_q <= {29'h0, evt_q};
      end else if (idx_w == IDX_MASK) begin
        rdata_q <= {29'h0, mask_q};
      end else if (idx_w == IDX_PIN_IN) begin
        rdata_q <= {30'h0, pin_q};
      end else if (idx_w == IDX_PORT_DIR) begin
        rdata_q <= {24'h0, port_dir_q};
      end else if (idx_w == IDX_PORT_OUT) begin
        rdata_q <= {24'h0, port_out_q};
      end else begin
        rdata_q <= 32'h0; // unmapped reads zero
      end
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;

  // ***************************************
  // software registers
  // ***************************************
  // control: bit 1 is written by the receiver only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CONTROL_RESET;
    end else begin
      if (wr_w && (idx_w == IDX_CONTROL) && avs_byteenable_i[0]) begin
        ctrl_q.rx_done_irq_en <= avs_writedata_i[7];
        ctrl_q.tx_done_irq_en <= avs_writedata_i[6];
        ctrl_q.data_empty_irq_en <= avs_writedata_i[5];
        ctrl_q.receiver_on <= avs_writedata_i[4];
        ctrl_q.transmitter_on <= avs_writedata_i[3];
        ctrl_q.nine_bit_select <= avs_writedata_i[2];
        ctrl_q.tx_ninth_bit <= avs_writedata_i[0];
      end
      // follows the data move: an overrun keeps the old character and its ninth bit
      if (rx_end_w && (!rx_done_q || rd_data_w) && ctrl_q.nine_bit_select) begin
        ctrl_q.rx_ninth_bit <= rx_shift_q[8];
      end
    end
  end

  // baud divisor, port direction, port data and interrupt mask
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      baud_q <= BAUD_RESET;
      port_dir_q <= PORT_RESET;
      port_out_q <= PORT_RESET;
      mask_q <= MASK_RESET;
    end else if (wr_w) begin
      if (idx_w == IDX_BAUD) begin
        if (avs_byteenable_i[0]) baud_q[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) baud_q[15:8] <= avs_writedata_i[15:8];
      end else if (idx_w == IDX_PORT_DIR && avs_byteenable_i[0]) begin
        port_dir_q <= avs_writedata_i[7:0];
      end else if (idx_w == IDX_PORT_OUT && avs_byteenable_i[0]) begin
        port_out_q <= avs_writedata_i[7:0];
      end else if (idx_w == IDX_MASK && avs_byteenable_i[0]) begin
        mask_q <= avs_writedata_i[2:0];
      end
    end
  end

  // ***************************************
  // pin synchronizer
  // ***************************************
  // three stages; a level is taken once stages two and three agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
      sync3_q <= 2'h3;
      pin_q <= 2'h3;
    end else begin
      sync1_q <= {tx_pin_i, rx_pin_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));
    end
  end

  // ***************************************
  // receiver
  // ***************************************
  assign rx_end_w = (rx_state_q == LINE_STOP) && (rx_cnt_q == 16'h0) && ctrl_q.receiver_on;
  assign rx_stop_w = pin_q[RX_PIN_BIT];

  // start, data lsb first, stop; halts at once when disabled
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_state_q <= LINE_IDLE;
      rx_cnt_q <= 16'h0;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 9'h0;
    end else if (!ctrl_q.receiver_on) begin
      rx_state_q <= LINE_IDLE;
    end else begin
      case (rx_state_q)
        LINE_IDLE: begin
          if (!pin_q[RX_PIN_BIT]) begin
            rx_state_q <= LINE_START;
            rx_cnt_q <= {1'b0, baud_q[15:1]};
          end
        end
        LINE_START: begin
          if (rx_cnt_q != 16'h0) begin
            rx_cnt_q <= rx_cnt_q - 16'h1;
          end else if (!pin_q[RX_PIN_BIT]) begin
            rx_state_q <= LINE_DATA;
            rx_cnt_q <= baud_q;
            rx_bit_q <= 4'h0;
          end else begin
            rx_state_q <= LINE_IDLE; // glitch, not a start bit
          end
        end
        LINE_DATA: begin
          if (rx_cnt_q != 16'h0) begin
            rx_cnt_q <= rx_cnt_q - 16'h1;
          end else begin
            rx_shift_q <= {pin_q[RX_PIN_BIT], rx_shift_q[8:1]};
            rx_cnt_q <= baud_q;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == last_bit_w) rx_state_q <= LINE_STOP;
          end
        end
        LINE_STOP: begin
          if (rx_cnt_q != 16'h0) begin
            rx_cnt_q <= rx_cnt_q - 16'h1;
          end else begin
            rx_state_q <= LINE_IDLE;
          end
        end
        default: rx_state_q <= LINE_IDLE;
      endcase
    end
  end

  // receive data and flags; disabling the receiver touches none of them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_data_q <= 8'h0;
      rx_done_q <= 1'b0;
      overrun_q <= 1'b0;
      framing_q <= 1'b0;
    end else if (rx_end_w) begin
      if (rx_done_q && !rd_data_w) begin
        overrun_q <= 1'b1;
      end else begin
        rx_data_q <= ctrl_q.nine_bit_select ? rx_shift_q[7:0] : rx_shift_q[8:1];
        overrun_q <= 1'b0;
        framing_q <= ~rx_stop_w;
      end
      rx_done_q <= 1'b1; // set wins over the read clear
    end else if (rd_data_w) begin
      rx_done_q <= 1'b0;
    end
  end

  // ***************************************
  // transmitter
  // ***************************************
  // a waiting character starts only when enabled, or follows on from a frame in flight
  assign tx_fin_w = (tx_state_q == LINE_STOP) && (tx_cnt_q == 16'h0);
  assign tx_load_w = txd_full_q && (tx_fin_w || (tx_state_q == LINE_IDLE && ctrl_q.transmitter_on));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_state_q <= LINE_IDLE;
      tx_cnt_q <= 16'h0;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 9'h1ff;
    end else if (tx_load_w) begin
      tx_state_q <= LINE_START;
      tx_cnt_q <= baud_q;
      tx_bit_q <= 4'h0;
      tx_shift_q <= {ctrl_q.tx_ninth_bit, txd_q};
    end else begin
      case (tx_state_q)
        LINE_IDLE: tx_state_q <= LINE_IDLE;
        LINE_START: begin
          if (tx_cnt_q != 16'h0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
          end else begin
            tx_state_q <= LINE_DATA;
            tx_cnt_q <= baud_q;
          end
        end
        LINE_DATA: begin
          if (tx_cnt_q != 16'h0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
          end else begin
            tx_shift_q <= {1'b1, tx_shift_q[8:1]};
            tx_cnt_q <= baud_q;
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == last_bit_w) tx_state_q <= LINE_STOP;
          end
        end
        LINE_STOP: begin
          if (tx_cnt_q != 16'h0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
          end else begin
            tx_state_q <= LINE_IDLE;
          end
        end
        default: tx_state_q <= LINE_IDLE;
      endcase
    end
  end

  // data register buffer; a write in the load cycle keeps it full
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txd_q <= 8'h0;
      txd_full_q <= 1'b0;
    end else if (wr_data_w) begin
      txd_q <= avs_writedata_i[7:0];
      txd_full_q <= 1'b1;
    end else if (tx_load_w) begin
      txd_full_q <= 1'b0;
    end
  end

  // transmit complete: set at frame end with nothing waiting, cleared by writing one
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_done_q <= 1'b0;
    end else if (tx_fin_w && !txd_full_q) begin
      tx_done_q <= 1'b1;
    end else if (wr_w && idx_w == IDX_STATUS && avs_byteenable_i[0] && avs_writedata_i[6]) begin
      tx_done_q <= 1'b0;
    end
  end

  // line level: low start, lsb first data, high stop and idle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_line_q <= 1'b1;
    end else begin
      case (tx_state_q)
        LINE_START: tx_line_q <= 1'b0;
        LINE_DATA: tx_line_q <= tx_shift_q[0];
        default: tx_line_q <= 1'b1;
      endcase
    end
  end

  // ***************************************
  // pin override
  // ***************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_pin_o <= 1'b0;
      tx_pin_oe_o <= 1'b0;
      rx_pin_o <= 1'b0;
      rx_pin_oe_o <= 1'b0;
      rx_pullup_o <= 1'b0;
    end else begin
      if (ctrl_q.transmitter_on || tx_state_q != LINE_IDLE) begin
        tx_pin_oe_o <= 1'b1;
        tx_pin_o <= tx_line_q;
      end else begin
        tx_pin_oe_o <= port_dir_q[TX_PIN_BIT];
        tx_pin_o <= port_out_q[TX_PIN_BIT];
      end
      rx_pin_o <= port_out_q[RX_PIN_BIT];
      if (ctrl_q.receiver_on) begin
        rx_pin_oe_o <= 1'b0;
        rx_pullup_o <= port_out_q[RX_PIN_BIT];
      end else begin
        rx_pin_oe_o <= port_dir_q[RX_PIN_BIT];
        rx_pullup_o <= ~port_dir_q[RX_PIN_BIT] & port_out_q[RX_PIN_BIT];
      end
    end
  end

  // ***************************************
  // interrupts
  // ***************************************
  // per-source requests follow flag and enable as a level
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_irq_o <= 1'b0;
      tx_irq_o <= 1'b0;
      empty_irq_o <= 1'b0;
    end else begin
      rx_irq_o <= global_irq_en_i & ctrl_q.rx_done_irq_en & rx_done_q;
      tx_irq_o <= global_irq_en_i & ctrl_q.tx_done_irq_en & tx_done_q;
      empty_irq_o <= global_irq_en_i & ctrl_q.data_empty_irq_en & ~txd_full_q;
    end
  end

  // sticky events cleared by a read of the event register, set wins
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      evt_q <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      evt_q <= ((rd_w && idx_w == IDX_EVENT) ? 3'h0 : evt_q) | {tx_load_w, tx_fin_w & ~txd_full_q, rx_end_w};
      irq_o <= |(evt_q & mask_q);
    end
  end

endmodule
`default_nettype wire

// ===== bench/uart_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_sva
  import uart_ctrl_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic global_irq_en_i,
  input wire logic rx_irq_o,
  input wire logic tx_irq_o,
  input wire logic empty_irq_o,
  input wire logic rx_pin_oe_o,
  input wire logic rx_pullup_o,
  input wire logic tx_pin_oe_o
);
  serial_control_t ctl_q;
  logic out0_q;
  logic [5:0] idx;
  logic wr_ok, rd_ok, mapped, pull_req;
  // decode of the access completing in this cycle
  assign idx = avs_address_i[7:2];
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  assign rd_ok = avs_read_i && !avs_waitrequest_o;
  assign mapped = idx inside {IDX_BAUD, IDX_CONTROL, IDX_STATUS, IDX_DATA, IDX_EVENT,
    IDX_MASK, IDX_PIN_IN, IDX_PORT_DIR, IDX_PORT_OUT};
  assign pull_req = ctl_q.receiver_on && out0_q;
  // shadow of the control register and of port data bit 0
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= serial_control_t'(CONTROL_RESET);
      out0_q <= 1'b0;
    end else if (wr_ok && idx == IDX_CONTROL) begin
      ctl_q <= serial_control_t'(avs_writedata_i[7:0]);
    end else if (wr_ok && idx == IDX_PORT_OUT) begin
      out0_q <= avs_writedata_i[RX_PIN_BIT];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_bus_one_wait : assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus access not answered after one wait cycle");
  a_unmapped_zero : assert property (
    rd_ok && !mapped |-> avs_readdata_o == 32'h0)
    else $error("unmapped read returned nonzero");
  a_status_reserved : assert property (
    rd_ok && idx == IDX_STATUS |-> avs_readdata_o[2:0] == 3'h0)
    else $error("reserved status bits not zero");
  a_rx_irq_gate : assert property (
    rx_irq_o |-> $past(global_irq_en_i) && $past(ctl_q.rx_done_irq_en))
    else $error("rx irq without its enables");
  a_tx_irq_gate : assert property (
    tx_irq_o |-> $past(global_irq_en_i) && $past(ctl_q.tx_done_irq_en))
    else $error("tx irq without its enables");
  a_empty_irq_gate : assert property (
    empty_irq_o |-> $past(global_irq_en_i) && $past(ctl_q.data_empty_irq_en))
    else $error("empty irq without its enables");
  a_tx_pin_out : assert property (
    ctl_q.transmitter_on && $past(ctl_q.transmitter_on) && $past(ctl_q.transmitter_on, 2) |-> tx_pin_oe_o)
    else $error("tx pin not driven while transmitter on");
  a_rx_pin_in : assert property (
    ctl_q.receiver_on && $past(ctl_q.receiver_on) && $past(ctl_q.receiver_on, 2) |-> !rx_pin_oe_o)
    else $error("rx pin driven while receiver on");
  a_rx_pullup_on : assert property (
    pull_req && $past(pull_req) && $past(pull_req, 2) |-> rx_pullup_o)
    else $error("rx pull-up off while forced input with data bit set");
endmodule
bind uart_ctrl uart_ctrl_sva i_sva (
  .clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .global_irq_en_i, .rx_irq_o, .tx_irq_o, .empty_irq_o,
  .rx_pin_oe_o, .rx_pullup_o, .tx_pin_oe_o
);
`default_nettype wire

// ===== bench/uart_remote.sv
`timescale 1ns/1ns
`default_nettype none
module uart_remote #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic [9:0] cap_q;
  int frames;
  // line idles high until a frame is sent
  initial line_o = 1'b1;
  // start low, data lsb first, stop, then idle high for a bit plus gap
  task automatic send_char(input logic [8:0] data, input int nbits, input logic stop, input int gap);
    for (int i = -1; i <= nbits; i++) begin
      line_o <= (i < 0) ? 1'b0 : (i == nbits) ? stop : data[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (BIT_CYC + gap) @(posedge clk_i);
  endtask
  // capture ten mid-bit samples after each start bit seen on the line
  initial begin
    frames = 0;
    cap_q = '0;
    forever begin
      @(posedge clk_i);
      if (line_i === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
          repeat (BIT_CYC) @(posedge clk_i);
          cap_q[i] = line_i;
        end
        frames++;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/uart_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_tb;
  import uart_ctrl_pkg::*;
  localparam int BIT_CYC = 8;
  logic clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o, global_irq_en_i;
  logic [7:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic rx_irq_o, tx_irq_o, empty_irq_o, irq_o;
  logic rx_pin_i, rx_pin_o, rx_pin_oe_o, rx_pullup_o, tx_pin_i, tx_pin_o, tx_pin_oe_o, remote_tx;
  int err_total = 0;
  int samples_checked = 0;
  int nf = 0;
  // released transmit line is pulled up; receive line is driven by whoever has it
  assign tx_pin_i = tx_pin_oe_o ? tx_pin_o : 1'b1;
  assign rx_pin_i = rx_pin_oe_o ? rx_pin_o : remote_tx;
  uart_ctrl i_dut (
    .clk_i, .resetn_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .global_irq_en_i, .rx_irq_o, .tx_irq_o, .empty_irq_o, .irq_o,
    .rx_pin_i, .rx_pin_o, .rx_pin_oe_o, .rx_pullup_o, .tx_pin_i, .tx_pin_o, .tx_pin_oe_o
  );
  uart_remote #(.BIT_CYC(BIT_CYC)) i_remote (.clk_i(clk_i), .line_i(tx_pin_i), .line_o(remote_tx));
  // 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ****************
  // helpers
  // ****************
  // verdict and end of run
  task automatic end_sim();
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // a wait bound ran out
  task automatic timeout();
    err_total++;
    $display("CHECK FAILED at %0t: wait bound used up", $time);
    end_sim();
  endtask
  // compare seen against expected
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= wd;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    for (int n = 0; n <= 50; n++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
      if (n == 50) timeout();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus_xfer(1'b1, idx, d, r);
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    bus_xfer(1'b0, idx, 32'h0, r);
    check(r & mask, exp);
  endtask
  // wait for the next frame at the remote end and compare it
  task automatic tx_frame(input logic [9:0] exp);
    nf++;
    for (int n = 0; n <= 4000; n++) begin
      if (i_remote.frames >= nf) break;
      if (n == 4000) timeout();
      @(posedge clk_i);
    end
    check(i_remote.cap_q, exp);
  endtask
  task automatic rx_send(input logic [8:0] d, input int nb, input logic stop, input int gap);
    i_remote.send_char(d, nb, stop, gap);
    idle(4);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rd_chk(IDX_CONTROL, 32'hff, 32'h02);
    rd_chk(IDX_STATUS, 32'h07, 32'h0);
    rd_chk(IDX_MASK, 32'hff, 32'h0);
    wr(6'h00, 32'hff);
    rd_chk(6'h00, 32'hffffffff, 32'h0);
  endtask
  task automatic t_pins();
    wr(IDX_BAUD, 32'h7);
    wr(IDX_PORT_DIR, 32'h01);
    wr(IDX_PORT_OUT, 32'h03);
    idle(2);
    check({rx_pin_oe_o, rx_pin_o, tx_pin_oe_o}, 3'b110);
    wr(IDX_CONTROL, 32'h18);
    idle(2);
    check({rx_pin_oe_o, tx_pin_oe_o, rx_pullup_o}, 3'b011);
    wr(IDX_PORT_OUT, 32'h02);
    idle(2);
    check(rx_pullup_o, 1'b0);
    wr(IDX_PORT_DIR, 32'h00);
    rd_chk(IDX_PIN_IN, 32'h3, 32'h3);
  endtask
  task automatic t_tx();
    wr(IDX_CONTROL, 32'h68);
    global_irq_en_i <= 1'b1;
    idle(3);
    check(empty_irq_o, 1'b1);
    wr(IDX_DATA, 32'ha5);
    tx_frame(10'h3a5);
    idle(BIT_CYC);
    check({tx_irq_o, empty_irq_o}, 2'b11);
    rd_chk(IDX_STATUS, 32'h60, 32'h60);
    wr(IDX_STATUS, 32'h40);
    idle(2);
    check({tx_irq_o, empty_irq_o}, 2'b01);
    wr(IDX_CONTROL, 32'h0d);
    idle(2);
    check(empty_irq_o, 1'b0);
    wr(IDX_DATA, 32'h5a);
    tx_frame(10'h35a);
    wr(IDX_CONTROL, 32'h0c);
    wr(IDX_DATA, 32'h11);
    idle(4);
    wr(IDX_DATA, 32'h22);
    wr(IDX_CONTROL, 32'h04);
    tx_frame(10'h211);
    tx_frame(10'h222);
    idle(2 * BIT_CYC);
    check(tx_pin_oe_o, 1'b0);
  endtask
  task automatic t_rx();
    wr(IDX_CONTROL, 32'h90);
    wr(IDX_MASK, 32'h1);
    rx_send(9'h03c, 8, 1'b1, 3 * BIT_CYC);
    rd_chk(IDX_STATUS, 32'h98, 32'h80);
    check({rx_irq_o, irq_o}, 2'b11);
    rd_chk(IDX_EVENT, 32'h1, 32'h1);
    idle(2);
    check(irq_o, 1'b0);
    rd_chk(IDX_DATA, 32'hff, 32'h3c);
    idle(2);
    check(rx_irq_o, 1'b0);
    global_irq_en_i <= 1'b0;
    rx_send(9'h055, 8, 1'b1, 0);
    check({rx_irq_o, irq_o}, 2'b01);
    global_irq_en_i <= 1'b1;
    wr(IDX_MASK, 32'h0);
    idle(2);
    check({rx_irq_o, irq_o}, 2'b10);
    rd_chk(IDX_EVENT, 32'h1, 32'h1);
    rd_chk(IDX_DATA, 32'hff, 32'h55);
  endtask
  task automatic t_rx_flags();
    rx_send(9'h001, 8, 1'b1, 0);
    rx_send(9'h002, 8, 1'b1, 0);
    rd_chk(IDX_STATUS, 32'h98, 32'h88);
    rd_chk(IDX_DATA, 32'hff, 32'h01);
    rx_send(9'h003, 8, 1'b1, 0);
    rd_chk(IDX_STATUS, 32'h98, 32'h80);
    rd_chk(IDX_DATA, 32'hff, 32'h03);
    rx_send(9'h004, 8, 1'b0, 0);
    rd_chk(IDX_STATUS, 32'h98, 32'h90);
    rd_chk(IDX_DATA, 32'hff, 32'h04);
    rx_send(9'h005, 8, 1'b1, 0);
    rd_chk(IDX_STATUS, 32'h98, 32'h80);
    rd_chk(IDX_DATA, 32'hff, 32'h05);
  endtask
  task automatic t_rx_nine();
    wr(IDX_CONTROL, 32'h14);
    rx_send(9'h1a5, 9, 1'b1, 0);
    rd_chk(IDX_CONTROL, 32'h2, 32'h2);
    rd_chk(IDX_DATA, 32'hff, 32'ha5);
    rx_send(9'h0c3, 9, 1'b1, 0);
    rd_chk(IDX_CONTROL, 32'h2, 32'h0);
    rd_chk(IDX_DATA, 32'hff, 32'hc3);
    rx_send(9'h011, 9, 1'b1, 0);
    wr(IDX_CONTROL, 32'h04);
    rd_chk(IDX_STATUS, 32'h98, 32'h80);
    rd_chk(IDX_DATA, 32'hff, 32'h11);
    rx_send(9'h066, 9, 1'b0, 0);
    rd_chk(IDX_STATUS, 32'h98, 32'h00);
  endtask
  // reset, then the scenarios in turn
  initial begin
    resetn_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h3;
    global_irq_en_i = 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_pins();
    t_tx();
    t_rx();
    t_rx_flags();
    t_rx_nine();
    end_sim();
  end
endmodule
`default_nettype wire
